//--- hw/fault_status_address_regs.v
// Fault status and fault address registers behind a classic Wishbone slave
// Behaviour
// - Hard fault status resets to zero; writing one clears a flag, zero keeps it.
// - Escalated flag sets when a configurable fault cannot be taken.
// - Vector fetch flag sets on a bus error reading the vector table.
// - Vector table bus errors always go to the hard fault handler.
// - Vector fetch fault stacks the address of the preempted instruction.
// - Memory management fault address holds the faulting address while valid.
// - Unaligned memory management fault captures the split aligned address that faulted.
// - Bus fault address holds the faulting location while its valid flag is set.
// - Unaligned bus fault captures the address the instruction requested.
// - Each auxiliary input high for one cycle sets its status bit.
// - Auxiliary bit stays set until software writes one; zero does nothing.
// - Auxiliary status bits never raise an exception.
// - Configurable status and priority registers accept byte, halfword and word.
// - Unaligned accesses to any register are not supported.
// - Bus address valid sets on a known-address bus fault; a later known-address memory management fault clears it.
// - Data access violation loads the attempted load or store address.
//
// The Wishbone register port was left to the implementer.
`include "fault_status_regs.vh"
`default_nettype none
module fault_status_address_regs #(
    parameter AUX_W = 32,
    parameter PRI_W = 8
) (
    input wire clk, // 125 MHz clock
    input wire rst_n, // Asynchronous reset, active low
    input wire ce, // Clock enable, freezes all state but the reset synchronizer when low
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    input wire wb_we_i, // Wishbone write enable
    input wire [7:0] wb_adr_i, // Wishbone byte address
    input wire [3:0] wb_sel_i, // Wishbone byte selects
    input wire [31:0] wb_dat_i, // Wishbone write data
    output reg [31:0] wb_dat_o, // Wishbone read data
    output reg wb_ack_o, // Wishbone acknowledge
    output reg wb_err_o, // Wishbone error, bad address or size
    input wire [2:0] cfg_fault_i, // Configurable fault events: mm, bus, usage
    input wire [2:0] fault_en_i, // Configurable fault handler enables
    input wire [PRI_W-1:0] exec_pri_i, // Current execution priority
    input wire vec_fetch_err_i, // Bus error on vector table read
    input wire [31:0] preempted_pc_i, // Address of the preempted instruction
    input wire mm_addr_known_i, // Memory management fault has an address
    input wire [31:0] mm_fault_addr_i, // Aligned access address that faulted
    input wire bus_addr_known_i, // Bus fault has an address
    input wire [31:0] bus_req_addr_i, // Address requested by the instruction
    input wire [AUX_W-1:0] aux_fault_inputs, // Auxiliary fault inputs
    output reg hard_fault_req_r, // Pulse: take the hard fault handler
    output reg [2:0] cfg_fault_req_r, // Pulse: take a configurable handler
    output reg [31:0] ret_addr_r // Return address to stack
);
    // Two-stage reset release
    reg rst_s1_r;
    reg rst_s2_r;
    wire srst_n;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign srst_n = rst_s2_r;

    // Bus decode
    wire req;
    reg hit_word;
    reg hit_sub;
    reg sel_sub_ok;
    reg [1:0] pri_idx;
    wire acc_ok;
    wire wr;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    always @* begin
        hit_word = 1'b0;
        hit_sub = 1'b0;
        pri_idx = 2'd0;
        case ({wb_adr_i[7:2], 2'b00})
            `OFS_HARD_FAULT_STATUS, `OFS_MEMMANAGE_FAULT_ADDRESS,
            `OFS_BUS_FAULT_ADDRESS, `OFS_AUXILIARY_FAULT_STATUS: begin
                hit_word = 1'b1;
            end
            `OFS_CFG_FAULT_STATUS: begin
                hit_sub = 1'b1;
            end
            `OFS_HANDLER_PRI1: begin
                hit_sub = 1'b1;
                pri_idx = 2'd0;
            end
            `OFS_HANDLER_PRI2: begin
                hit_sub = 1'b1;
                pri_idx = 2'd1;
            end
            `OFS_HANDLER_PRI3: begin
                hit_sub = 1'b1;
                pri_idx = 2'd2;
            end
            default: begin
                hit_word = 1'b0;
            end
        endcase
    end

    // Only naturally aligned lanes count; anything else is an unaligned access
    always @* begin
        case (wb_sel_i)
            `SEL_WORD, `SEL_HALF_LO, `SEL_HALF_HI,
            `SEL_BYTE0, `SEL_BYTE1, `SEL_BYTE2, `SEL_BYTE3: begin
                sel_sub_ok = 1'b1;
            end
            default: begin
                sel_sub_ok = 1'b0;
            end
        endcase
    end

    // Word-only registers refuse partial accesses with an error and no effect
    assign acc_ok = (hit_word && wb_sel_i == `SEL_WORD) || (hit_sub && sel_sub_ok);
    assign wr = req && acc_ok && wb_we_i;

    wire [31:0] lane_mask;
    assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    wire wr_hfs;
    wire wr_memmanage_fault_address;
    wire wr_bus_fault_address;
    wire wr_afs;
    wire wr_cfs;
    assign wr_hfs = wr && {wb_adr_i[7:2], 2'b00} == `OFS_HARD_FAULT_STATUS;
    assign wr_memmanage_fault_address = wr && {wb_adr_i[7:2], 2'b00} == `OFS_MEMMANAGE_FAULT_ADDRESS;
    assign wr_bus_fault_address = wr && {wb_adr_i[7:2], 2'b00} == `OFS_BUS_FAULT_ADDRESS;
    assign wr_afs = wr && {wb_adr_i[7:2], 2'b00} == `OFS_AUXILIARY_FAULT_STATUS;
    assign wr_cfs = wr && {wb_adr_i[7:2], 2'b00} == `OFS_CFG_FAULT_STATUS;

    // Handler priority registers, byte addressable
    reg [31:0] pri_r [0:2];
    integer i;

    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            for (i = 0; i < 3; i = i + 1) begin
                pri_r[i] <= `HANDLER_PRI_RESET;
            end
        end else if (ce && wr && hit_sub && !wr_cfs) begin
            pri_r[pri_idx] <= (pri_r[pri_idx] & ~lane_mask) | (wb_dat_i & lane_mask);
        end
    end

    // Escalation: a fault that is disabled or cannot preempt becomes a hard fault
    reg [2:0] can_take;
    reg [PRI_W-1:0] hpri;
    integer k;

    always @* begin
        can_take = 3'b000;
        hpri = {PRI_W{1'b0}};
        for (k = 0; k < 3; k = k + 1) begin
            hpri = pri_r[0][8*k +: PRI_W];
            can_take[k] = fault_en_i[k] && (hpri < exec_pri_i);
        end
    end

    wire escalate;
    assign escalate = |(cfg_fault_i & ~can_take);

    // Hard fault status flags: only the forced and vector fetch bits exist
    wire [31:0] hfs_set;
    wire [31:0] hfs_clr;
    wire [31:0] hfs_q;
    assign hfs_set = ({31'h0, escalate} << `HFS_FORCED_BIT)
                   | ({31'h0, vec_fetch_err_i} << `HFS_VECTOR_FETCH_BIT);
    // Top bit and reserved bits ignore writes; software owes zero to the top bit
    assign hfs_clr = wr_hfs ? (wb_dat_i & (({31'h0, 1'b1} << `HFS_FORCED_BIT)
                   | ({31'h0, 1'b1} << `HFS_VECTOR_FETCH_BIT))) : 32'h0;

    sticky_flags #(
        .WIDTH(32),
        .RESET_VAL(`HARD_FAULT_STATUS_RESET)
    ) u_hard_fault_status (
        .clk(clk),
        .rst_n(srst_n),
        .ce(ce),
        .set_i(hfs_set),
        .clr_i(hfs_clr),
        .q_r(hfs_q)
    );

    // Auxiliary status: a one-cycle high level is enough to latch
    wire [AUX_W-1:0] afs_q;
    wire [AUX_W-1:0] afs_clr;
    assign afs_clr = wr_afs ? wb_dat_i[AUX_W-1:0] : {AUX_W{1'b0}};

    sticky_flags #(
        .WIDTH(AUX_W),
        .RESET_VAL(`AUX_FAULT_STATUS_RESET)
    ) u_aux_fault_status (
        .clk(clk),
        .rst_n(srst_n),
        .ce(ce),
        .set_i(aux_fault_inputs),
        .clr_i(afs_clr),
        .q_r(afs_q)
    );

    // Fault address capture
    wire mm_cap;
    wire bus_cap;
    wire [31:0] memmanage_fault_address_q;
    wire [31:0] bus_fault_address_q;
    wire mm_valid;
    wire bus_valid;
    assign mm_cap = cfg_fault_i[`FAULT_MM] && mm_addr_known_i;
    assign bus_cap = cfg_fault_i[`FAULT_BUS] && bus_addr_known_i;

    fault_addr_capture #(
        .AW(32)
    ) u_memmanage_fault_address (
        .clk(clk),
        .rst_n(srst_n),
        .ce(ce),
        .capture_i(mm_cap),
        .addr_i(mm_fault_addr_i),
        .invalidate_i(1'b0),
        .sw_we_i(wr_memmanage_fault_address),
        .sw_data_i(wb_dat_i),
        .sw_clr_valid_i(wr_cfs && wb_sel_i[0] && wb_dat_i[`CFS_MM_VALID_BIT]),
        .addr_r(memmanage_fault_address_q),
        .valid_r(mm_valid)
    );

    fault_addr_capture #(
        .AW(32)
    ) u_bus_fault_address (
        .clk(clk),
        .rst_n(srst_n),
        .ce(ce),
        .capture_i(bus_cap),
        .addr_i(bus_req_addr_i),
        .invalidate_i(mm_cap),
        .sw_we_i(wr_bus_fault_address),
        .sw_data_i(wb_dat_i),
        .sw_clr_valid_i(wr_cfs && wb_sel_i[1] && wb_dat_i[`CFS_BUS_VALID_BIT]),
        .addr_r(bus_fault_address_q),
        .valid_r(bus_valid)
    );

    // Read data
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0;
        case ({wb_adr_i[7:2], 2'b00})
            `OFS_HANDLER_PRI1: begin
                rd_nxt = pri_r[0];
            end
            `OFS_HANDLER_PRI2: begin
                rd_nxt = pri_r[1];
            end
            `OFS_HANDLER_PRI3: begin
                rd_nxt = pri_r[2];
            end
            `OFS_CFG_FAULT_STATUS: begin
                rd_nxt[`CFS_MM_VALID_BIT] = mm_valid;
                rd_nxt[`CFS_BUS_VALID_BIT] = bus_valid;
            end
            `OFS_HARD_FAULT_STATUS: begin
                rd_nxt[`HFS_FORCED_BIT] = hfs_q[`HFS_FORCED_BIT];
                rd_nxt[`HFS_VECTOR_FETCH_BIT] = hfs_q[`HFS_VECTOR_FETCH_BIT];
            end
            `OFS_MEMMANAGE_FAULT_ADDRESS: begin
                rd_nxt = memmanage_fault_address_q;
            end
            `OFS_BUS_FAULT_ADDRESS: begin
                rd_nxt = bus_fault_address_q;
            end
            `OFS_AUXILIARY_FAULT_STATUS: begin
                rd_nxt[AUX_W-1:0] = afs_q;
            end
            default: begin
                rd_nxt = 32'h0;
            end
        endcase
    end

    // Answer one cycle after the request; error for bad address or lanes
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce) begin
            wb_ack_o <= req && acc_ok;
            wb_err_o <= req && !acc_ok;
            if (req && acc_ok && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // Exception routing; auxiliary status is deliberately not connected here
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            hard_fault_req_r <= 1'b0;
            cfg_fault_req_r <= 3'b000;
            ret_addr_r <= 32'h0;
        end else if (ce) begin
            hard_fault_req_r <= escalate || vec_fetch_err_i;
            // A vector fetch error preempts configurable handlers
            cfg_fault_req_r <= vec_fetch_err_i ? 3'b000 : (cfg_fault_i & can_take);
            if (vec_fetch_err_i) begin
                ret_addr_r <= preempted_pc_i;
            end
        end
    end
endmodule
`default_nettype wire

//--- common/fault_status_regs.vh
// Register map, field positions and reset values of the fault status block
`ifndef FAULT_STATUS_REGS_VH
`define FAULT_STATUS_REGS_VH

`define OFS_HANDLER_PRI1 8'h18
`define OFS_HANDLER_PRI2 8'h1c
`define OFS_HANDLER_PRI3 8'h20
`define OFS_CFG_FAULT_STATUS 8'h28
`define OFS_HARD_FAULT_STATUS 8'h2c
`define OFS_MEMMANAGE_FAULT_ADDRESS 8'h34
`define OFS_BUS_FAULT_ADDRESS 8'h38
`define OFS_AUXILIARY_FAULT_STATUS 8'h3c

`define HFS_DEBUG_RESERVED_BIT 31
`define HFS_FORCED_BIT 30
`define HFS_VECTOR_FETCH_BIT 1
`define CFS_MM_VALID_BIT 7
`define CFS_BUS_VALID_BIT 15

`define HARD_FAULT_STATUS_RESET 32'h0000_0000
`define FAULT_ADDRESS_RESET 32'h0000_0000
`define AUX_FAULT_STATUS_RESET 32'h0000_0000
`define HANDLER_PRI_RESET 32'h0000_0000

`define SEL_WORD 4'hf
`define SEL_HALF_LO 4'h3
`define SEL_HALF_HI 4'hc
`define SEL_BYTE0 4'h1
`define SEL_BYTE1 4'h2
`define SEL_BYTE2 4'h4
`define SEL_BYTE3 4'h8

`define FAULT_MM 0
`define FAULT_BUS 1
`define FAULT_USAGE 2

`endif

//--- hw/sticky_flags.v
// Sticky flag bank: hardware sets, software clears by writing one
`default_nettype none
module sticky_flags #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk, // Clock
    input wire rst_n, // Synchronised reset, active low
    input wire ce, // Clock enable
    input wire [WIDTH-1:0] set_i, // Hardware set pulses
    input wire [WIDTH-1:0] clr_i, // Software clear pulses
    output reg [WIDTH-1:0] q_r // Flag state
);
    wire [WIDTH-1:0] q_nxt;

    // A set in the same cycle as a clear keeps the flag, so no event is lost
    assign q_nxt = (q_r & ~clr_i) | set_i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= RESET_VAL;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end
endmodule
`default_nettype wire

//--- hw/fault_addr_capture.v
// Fault address register with its validity flag
`include "fault_status_regs.vh"
`default_nettype none
module fault_addr_capture #(
    parameter AW = 32
) (
    input wire clk, // Clock
    input wire rst_n, // Synchronised reset, active low
    input wire ce, // Clock enable
    input wire capture_i, // Fault with known address
    input wire [AW-1:0] addr_i, // Address to capture
    input wire invalidate_i, // Later fault clears validity
    input wire sw_we_i, // Software writes the address
    input wire [AW-1:0] sw_data_i, // Software write data
    input wire sw_clr_valid_i, // Software clears validity
    output reg [AW-1:0] addr_r, // Captured address
    output reg valid_r // Address is valid
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= `FAULT_ADDRESS_RESET;
            valid_r <= 1'b0;
        end else if (ce) begin
            // Hardware capture wins over a software write in the same cycle
            if (capture_i) begin
                addr_r <= addr_i;
            end else if (sw_we_i) begin
                addr_r <= sw_data_i;
            end
            if (capture_i) begin
                valid_r <= 1'b1;
            end else if (invalidate_i || sw_clr_valid_i) begin
                valid_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/fault_status_address_regs_checker.sv
// Port-level assertions for the fault status block
`default_nettype none
module fault_status_address_regs_checker #(
    parameter AUX_W = 32
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic wb_ack_o, // Acknowledge
    input wire logic wb_err_o, // Error answer
    input wire logic [2:0] cfg_fault_i, // Fault events
    input wire logic [2:0] fault_en_i, // Handler enables
    input wire logic vec_fetch_err_i, // Vector read error
    input wire logic [31:0] preempted_pc_i, // Preempted address
    input wire logic [AUX_W-1:0] aux_fault_inputs, // Auxiliary inputs
    input wire logic hard_fault_req_r, // Hard fault request
    input wire logic [2:0] cfg_fault_req_r, // Configurable requests
    input wire logic [31:0] ret_addr_r // Stacked return address
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] up_r;
    logic live;
    logic req;
    logic wrd;
    logic byt;
    logic lane;
    // The design holds its own reset copy for two more edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end
    assign live = up_r == 2'h3;
    assign req = live && ce && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wrd = wb_adr_i[7:2] inside {6'hb, 6'hd, 6'he, 6'hf};
    assign byt = wb_adr_i[7:2] inside {6'h6, 6'h7, 6'h8, 6'ha};
    assign lane = wb_sel_i inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_word_size_err: assert property (req && wrd && wb_sel_i != 4'hf |=> wb_err_o && !wb_ack_o)
        else $error("word register took a partial access");
    a_byte_lane_ack: assert property (req && byt && lane |=> wb_ack_o && !wb_err_o)
        else $error("legal lanes refused");
    a_answer_once: assert property (req |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o))
        else $error("bus answer not a single pulse");
    a_escalate_hard: assert property (live && ce && (cfg_fault_i & ~fault_en_i) != 3'h0 |=> hard_fault_req_r)
        else $error("disabled fault not escalated");
    a_vector_hard: assert property (live && ce && vec_fetch_err_i |=> hard_fault_req_r && cfg_fault_req_r == 3'h0)
        else $error("vector read error not sent to hard handler");
    a_vector_retaddr: assert property (live && ce && vec_fetch_err_i |=> ret_addr_r == $past(preempted_pc_i))
        else $error("wrong return address");
    a_ret_hold: assert property (live && ce && !vec_fetch_err_i |=> $stable(ret_addr_r))
        else $error("return address moved");
    a_aux_no_exc: assert property (live && ce && |aux_fault_inputs && cfg_fault_i == 3'h0 && !vec_fetch_err_i
        |=> !hard_fault_req_r && cfg_fault_req_r == 3'h0)
        else $error("auxiliary input raised a request");
    c_refused: cover property (req ##1 wb_err_o);
    c_vector: cover property (vec_fetch_err_i ##1 hard_fault_req_r);
    c_taken: cover property (cfg_fault_req_r[1]);
endmodule
`default_nettype wire

//--- verification/fault_status_address_regs_bench.sv
// Self-checking bench for the fault status and address registers
`default_nettype none
module fault_status_address_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic vec_fetch_err_i = 1'h0, mm_addr_known_i = 1'h0, bus_addr_known_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h0, exec_pri_i = 8'h40;
    logic [3:0] wb_sel_i = 4'h0;
    logic [2:0] cfg_fault_i = 3'h0, fault_en_i = 3'h0, cfg_fault_req_r;
    logic [31:0] wb_dat_i = 32'h0, mm_fault_addr_i = 32'h0, bus_req_addr_i = 32'h0;
    logic [31:0] preempted_pc_i = 32'h0, aux_fault_inputs = 32'h0, wb_dat_o, ret_addr_r, q, a;
    logic [31:0] m_hf = 32'h0, m_mm = 32'h0, m_bf = 32'h0, m_af = 32'h0, m_v = 32'h0;
    logic wb_ack_o, wb_err_o, hard_fault_req_r, e;
    integer fail_count = 0, checks_done = 0, seed = 32'hae9d, i;

    fault_status_address_regs #(.AUX_W(32), .PRI_W(8)) fault_status_address_regs_i (
        .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .cfg_fault_i(cfg_fault_i), .fault_en_i(fault_en_i), .exec_pri_i(exec_pri_i),
        .vec_fetch_err_i(vec_fetch_err_i), .preempted_pc_i(preempted_pc_i), .mm_addr_known_i(mm_addr_known_i),
        .mm_fault_addr_i(mm_fault_addr_i), .bus_addr_known_i(bus_addr_known_i),
        .bus_req_addr_i(bus_req_addr_i), .aux_fault_inputs(aux_fault_inputs),
        .hard_fault_req_r(hard_fault_req_r), .cfg_fault_req_r(cfg_fault_req_r), .ret_addr_r(ret_addr_r)
    );

    always #4 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] ad, input logic [3:0] s, input logic [31:0] d,
                       input logic xe);
        @(posedge clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= ad;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // No answer at all is left to the watchdog
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        chk({31'h0, e}, {31'h0, xe});
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        acc(1'h1, ad, 4'hf, d, 1'h0);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] x);
        acc(1'h0, ad, 4'hf, 32'h0, 1'h0);
        chk(q, x);
    endtask

    // Holds every event for exactly one taken edge, then samples the one-cycle answer
    task automatic ev(input logic [2:0] f, input logic [2:0] en, input logic v, input logic [31:0] ad,
                      input logic [31:0] x);
        @(posedge clk);
        cfg_fault_i <= f;
        fault_en_i <= en;
        mm_addr_known_i <= f[0];
        bus_addr_known_i <= f[1];
        mm_fault_addr_i <= ad;
        bus_req_addr_i <= ~ad;
        vec_fetch_err_i <= v;
        preempted_pc_i <= ad;
        aux_fault_inputs <= x;
        @(posedge clk);
        cfg_fault_i <= 3'h0;
        vec_fetch_err_i <= 1'h0;
        aux_fault_inputs <= 32'h0;
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #40000;
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rd(8'h2c, 32'h0);
        rd(8'h3c, 32'h0);
        for (i = 0; i < 15; i++)
            acc(1'h0, 8'h2c + 8'(4 * (i % 4)), i[3:0], 32'h0, 1'h1);
        acc(1'h0, 8'h30, 4'hf, 32'h0, 1'h1);
        for (i = 0; i < 16; i++)
            acc(1'h1, 8'h1c, i[3:0], 32'hffff_ffff, !(i inside {1, 2, 4, 8, 3, 12, 15}));
        acc(1'h1, 8'h1c, 4'h4, 32'h0, 1'h0);
        rd(8'h1c, 32'hff00_ffff);
        a = $random(seed);
        wr(8'h34, a);
        m_mm = a;
        rd(8'h34, m_mm);
        wr(8'h38, ~a);
        m_bf = ~a;
        acc(1'h1, 8'h38, 4'h3, 32'h0, 1'h1);
        rd(8'h38, m_bf);
        wr(8'h18, 32'h0000_1020);
        for (i = 0; i < 6; i++) begin
            a = $random(seed);
            ev(3'h1 << (i % 3), (i < 3) ? 3'h7 : 3'h0, 1'h0, a, 32'h0);
            chk({31'h0, hard_fault_req_r}, {31'h0, i >= 3});
            chk({29'h0, cfg_fault_req_r}, (i < 3) ? 32'h1 << (i % 3) : 32'h0);
            if (i % 3 == 0)
                m_mm = a;
            if (i % 3 == 0)
                m_v = 32'h80;
            if (i % 3 == 1)
                m_bf = ~a;
            if (i % 3 == 1)
                m_v = m_v | 32'h8000;
            if (i >= 3)
                m_hf = m_hf | 32'h4000_0000;
            rd(8'h34, m_mm);
            rd(8'h38, m_bf);
            rd(8'h28, m_v);
        end
        for (i = 16; i < 18; i++) begin
            exec_pri_i <= i[7:0];
            ev(3'h2, 3'h7, 1'h0, 32'h0, 32'h0);
            chk({31'h0, hard_fault_req_r}, {31'h0, i == 16});
        end
        rd(8'h2c, m_hf);
        a = $random(seed);
        ev(3'h4, 3'h7, 1'h1, a, 32'h0);
        chk(ret_addr_r, a);
        chk({28'h0, hard_fault_req_r, cfg_fault_req_r}, 32'h8);
        m_hf = m_hf | 32'h2;
        rd(8'h2c, m_hf);
        wr(8'h2c, 32'h3fff_fffd);
        rd(8'h2c, m_hf);
        wr(8'h2c, 32'h4000_0000);
        rd(8'h2c, 32'h2);
        wr(8'h2c, 32'h2);
        rd(8'h2c, 32'h0);
        for (i = 0; i < 8; i++) begin
            a = $random(seed);
            ev(3'h0, 3'h7, 1'h0, 32'h0, a);
            chk({31'h0, hard_fault_req_r}, 32'h0);
            m_af = m_af | a;
            rd(8'h3c, m_af);
            a = $random(seed);
            wr(8'h3c, a);
            m_af = m_af & ~a;
            rd(8'h3c, m_af);
        end
        // Clock enable low: a disabled fault with an address and an auxiliary pulse leave no trace
        ce <= 1'h0;
        ev(3'h1, 3'h0, 1'h0, 32'h0, 32'hffff_ffff);
        chk({31'h0, hard_fault_req_r}, 32'h0);
        @(posedge clk);
        ce <= 1'h1;
        rd(8'h34, m_mm);
        rd(8'h28, m_v);
        rd(8'h2c, 32'h0);
        rd(8'h3c, m_af);
        print_verdict();
    end
endmodule

bind fault_status_address_regs fault_status_address_regs_checker #(.AUX_W(AUX_W))
    fault_status_address_regs_checker_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cfg_fault_i(cfg_fault_i),
    .fault_en_i(fault_en_i), .vec_fetch_err_i(vec_fetch_err_i), .preempted_pc_i(preempted_pc_i),
    .aux_fault_inputs(aux_fault_inputs), .hard_fault_req_r(hard_fault_req_r),
    .cfg_fault_req_r(cfg_fault_req_r), .ret_addr_r(ret_addr_r)
);
`default_nettype wire
